// File: bpi_barrier_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Barrier halves share ID, type, domain, protection
// - Narrower channel ID zero-extended to wider
// - Pairs issued in same order both channels
// - Several barriers may be outstanding; lite unlimited
// - Full master: at most 256 outstanding
// - Outstanding from pair acceptance to both responses
// - Barrier IDs kept apart from normal IDs; here user IDs held only while a barrier is open, snoop IDs unchecked
// - Earlier-issued per channel counts as pre-barrier
// - Ordered transactions wait for both responses
// - Unordered traffic may pass an open barrier
// - Write half issued without waiting on reads
// - Read half issued without waiting on writes
// - Write half never needs later reads
// - Lite: read half never needs later writes
// - Full: read half never needs ordered writes
// - Snoop writebacks never blocked by barriers
// - Ordered shareable cache stores wait for responses
// - Ordered shareable cache loads wait for responses
// - Snoop writes proceed with read channel stalled
module bpi_barrier_ctrl
    import bpi_pkg::*;
#(
    parameter int         ARID_W = 4,
    parameter int         AWID_W = 6,
    parameter int         ADDR_W = 32,
    parameter bit         LITE   = 1'b0,
    // Arbitrary reserved barrier ID
    parameter logic [3:0] BAR_ID = 4'hf
) (
    input  wire logic                  mclk_i,
    input  wire logic                  srst_i,
    input  wire logic                  bar_req_valid_i,
    output logic                       bar_req_ready_o,
    input  wire logic [BPI_BAR_W-1:0]  bar_req_kind_i,
    input  wire logic [BPI_DOM_W-1:0]  bar_req_dom_i,
    input  wire logic [BPI_PROT_W-1:0] bar_req_prot_i,
    input  wire logic                  rd_req_valid_i,
    output logic                       rd_req_ready_o,
    input  wire logic                  rd_req_ordered_i,
    input  wire logic [ARID_W-1:0]     rd_req_id_i,
    input  wire logic [ADDR_W-1:0]     rd_req_addr_i,
    input  wire logic [BPI_DOM_W-1:0]  rd_req_dom_i,
    input  wire logic [BPI_PROT_W-1:0] rd_req_prot_i,
    input  wire logic                  wr_req_valid_i,
    output logic                       wr_req_ready_o,
    input  wire logic                  wr_req_ordered_i,
    input  wire logic [AWID_W-1:0]     wr_req_id_i,
    input  wire logic [ADDR_W-1:0]     wr_req_addr_i,
    input  wire logic [BPI_DOM_W-1:0]  wr_req_dom_i,
    input  wire logic [BPI_PROT_W-1:0] wr_req_prot_i,
    input  wire logic                  snp_wr_valid_i,
    output logic                       snp_wr_ready_o,
    input  wire logic [AWID_W-1:0]     snp_wr_id_i,
    input  wire logic [ADDR_W-1:0]     snp_wr_addr_i,
    input  wire logic                  cache_ld_req_i,
    output logic                       cache_ld_go_o,
    input  wire logic                  cache_st_req_i,
    output logic                       cache_st_go_o,
    output logic                       ar_valid_o,
    input  wire logic                  ar_ready_i,
    output logic [ARID_W-1:0]          ar_id_o,
    output logic [ADDR_W-1:0]          ar_addr_o,
    output logic [BPI_BAR_W-1:0]       ar_bar_o,
    output logic [BPI_DOM_W-1:0]       ar_domain_o,
    output logic [BPI_PROT_W-1:0]      ar_prot_o,
    output logic                       aw_valid_o,
    input  wire logic                  aw_ready_i,
    output logic [AWID_W-1:0]          aw_id_o,
    output logic [ADDR_W-1:0]          aw_addr_o,
    output logic [BPI_BAR_W-1:0]       aw_bar_o,
    output logic [BPI_DOM_W-1:0]       aw_domain_o,
    output logic [BPI_PROT_W-1:0]      aw_prot_o,
    input  wire logic                  r_valid_i,
    output logic                       r_ready_o,
    input  wire logic [ARID_W-1:0]     r_id_i,
    input  wire logic                  r_last_i,
    output logic                       usr_r_valid_o,
    input  wire logic                  usr_r_ready_i,
    input  wire logic                  b_valid_i,
    output logic                       b_ready_o,
    input  wire logic [AWID_W-1:0]     b_id_i,
    output logic                       usr_b_valid_o,
    input  wire logic                  usr_b_ready_i,
    output logic [BPI_CNT_W-1:0]       bar_outstanding_o
);

    // ************************************************************
    // Barrier identity and pair state
    // ************************************************************
    localparam logic [ARID_W-1:0] AR_BAR_ID = ARID_W'(BAR_ID);
    localparam logic [AWID_W-1:0] AW_BAR_ID = AWID_W'(BAR_ID);

    logic                   ar_half_r, ar_half_nxt;
    logic                   aw_half_r, aw_half_nxt;
    logic [BPI_BAR_W-1:0]   kind_r,    kind_nxt;
    logic [BPI_DOM_W-1:0]   dom_r,     dom_nxt;
    logic [BPI_PROT_W-1:0]  prot_r,    prot_nxt;
    logic [BPI_CNT_W-1:0]   cnt_r,     cnt_nxt;
    logic [BPI_CNT_W-1:0]   rsp_r_r,   rsp_r_nxt;
    logic [BPI_CNT_W-1:0]   rsp_b_r,   rsp_b_nxt;
    logic                   ar_load,   aw_load;
    logic                   ar_is_bar, aw_is_bar;
    logic                   accept,    done;
    logic                   r_hit,     b_hit;
    logic                   fence_clr, room;
    logic                   rd_gate,   wr_gate;
    logic                   rd_usr_rdy, wr_usr_rdy;

    // ************************************************************
    // Acceptance of a new pair
    // ************************************************************
    // One pair in flight on the address side keeps channel order
    assign room            = LITE || (cnt_r < BPI_CNT_LIMIT);
    assign bar_req_ready_o = !ar_half_r && !aw_half_r && room;
    assign accept          = bar_req_valid_i && bar_req_ready_o;

    // ************************************************************
    // Barrier responses: absorbed here, never shown to the user
    // ************************************************************
    assign r_hit         = r_valid_i && (r_id_i == AR_BAR_ID) && r_last_i;
    assign b_hit         = b_valid_i && (b_id_i == AW_BAR_ID);
    assign r_ready_o     = r_hit || usr_r_ready_i;
    assign b_ready_o     = b_hit || usr_b_ready_i;
    assign usr_r_valid_o = r_valid_i && !r_hit;
    assign usr_b_valid_o = b_valid_i && !b_hit;
    // Responses arrive in either order; a pair closes with one of each
    assign done = ((rsp_r_r != '0) || r_hit) && ((rsp_b_r != '0) || b_hit);

    always_comb begin
        ar_half_nxt = ar_half_r;
        aw_half_nxt = aw_half_r;
        kind_nxt    = kind_r;
        dom_nxt     = dom_r;
        prot_nxt    = prot_r;
        if (accept) begin
            ar_half_nxt = 1'b1;
            aw_half_nxt = 1'b1;
            kind_nxt    = bar_req_kind_i;
            dom_nxt     = bar_req_dom_i;
            prot_nxt    = bar_req_prot_i;
        end
        // Each half leaves on its own slot, independent of the other
        if (ar_load) begin
            ar_half_nxt = 1'b0;
        end
        if (aw_load) begin
            aw_half_nxt = 1'b0;
        end
        cnt_nxt   = cnt_r + BPI_CNT_W'(accept) - BPI_CNT_W'(done);
        rsp_r_nxt = rsp_r_r + BPI_CNT_W'(r_hit) - BPI_CNT_W'(done);
        rsp_b_nxt = rsp_b_r + BPI_CNT_W'(b_hit) - BPI_CNT_W'(done);
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ar_half_r <= 1'b0;
            aw_half_r <= 1'b0;
            kind_r    <= BPI_BAR_NONE;
            dom_r     <= BPI_DOM_RST;
            prot_r    <= BPI_PROT_RST;
            cnt_r     <= BPI_CNT_RST;
            rsp_r_r   <= BPI_CNT_RST;
            rsp_b_r   <= BPI_CNT_RST;
        end else begin
            ar_half_r <= ar_half_nxt;
            aw_half_r <= aw_half_nxt;
            kind_r    <= kind_nxt;
            dom_r     <= dom_nxt;
            prot_r    <= prot_nxt;
            cnt_r     <= cnt_nxt;
            rsp_r_r   <= rsp_r_nxt;
            rsp_b_r   <= rsp_b_nxt;
        end
    end

    assign bar_outstanding_o = cnt_r;

    // ************************************************************
    // Fence on ordered traffic and local cache accesses
    // ************************************************************
    assign fence_clr = (cnt_r == BPI_CNT_RST);
    // Unordered traffic may pass; reuse of the barrier ID waits
    assign rd_gate = fence_clr || (!rd_req_ordered_i && (rd_req_id_i != AR_BAR_ID));
    assign wr_gate = fence_clr || (!wr_req_ordered_i && (wr_req_id_i != AW_BAR_ID));
    assign rd_req_ready_o = rd_usr_rdy && rd_gate;
    assign wr_req_ready_o = wr_usr_rdy && wr_gate;
    assign cache_ld_go_o  = cache_ld_req_i && fence_clr;
    assign cache_st_go_o  = cache_st_req_i && fence_clr;

    // ************************************************************
    // Address channels
    // ************************************************************
    // Read slot never waits on writes, write slot never on reads
    // Anything already in a slot is ahead of the barrier there
    bpi_addr_slot #(.ID_W(ARID_W), .ADDR_W(ADDR_W)) u_ar_slot (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .pri_valid_i (1'b0),
        .pri_ready_o (),
        .pri_id_i    ('0),
        .pri_addr_i  ('0),
        .bar_want_i  (ar_half_r),
        .bar_id_i    (AR_BAR_ID),
        .bar_kind_i  (kind_r),
        .bar_dom_i   (dom_r),
        .bar_prot_i  (prot_r),
        .bar_load_o  (ar_load),
        .usr_valid_i (rd_req_valid_i && rd_gate),
        .usr_ready_o (rd_usr_rdy),
        .usr_id_i    (rd_req_id_i),
        .usr_addr_i  (rd_req_addr_i),
        .usr_dom_i   (rd_req_dom_i),
        .usr_prot_i  (rd_req_prot_i),
        .ax_valid_o  (ar_valid_o),
        .ax_ready_i  (ar_ready_i),
        .ax_id_o     (ar_id_o),
        .ax_addr_o   (ar_addr_o),
        .ax_bar_o    (ar_bar_o),
        .ax_dom_o    (ar_domain_o),
        .ax_prot_o   (ar_prot_o),
        .ax_is_bar_o (ar_is_bar)
    );

    // Snoop writes take the write slot ahead of barriers
    bpi_addr_slot #(.ID_W(AWID_W), .ADDR_W(ADDR_W)) u_aw_slot (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .pri_valid_i (snp_wr_valid_i),
        .pri_ready_o (snp_wr_ready_o),
        .pri_id_i    (snp_wr_id_i),
        .pri_addr_i  (snp_wr_addr_i),
        .bar_want_i  (aw_half_r),
        .bar_id_i    (AW_BAR_ID),
        .bar_kind_i  (kind_r),
        .bar_dom_i   (dom_r),
        .bar_prot_i  (prot_r),
        .bar_load_o  (aw_load),
        .usr_valid_i (wr_req_valid_i && wr_gate),
        .usr_ready_o (wr_usr_rdy),
        .usr_id_i    (wr_req_id_i),
        .usr_addr_i  (wr_req_addr_i),
        .usr_dom_i   (wr_req_dom_i),
        .usr_prot_i  (wr_req_prot_i),
        .ax_valid_o  (aw_valid_o),
        .ax_ready_i  (aw_ready_i),
        .ax_id_o     (aw_id_o),
        .ax_addr_o   (aw_addr_o),
        .ax_bar_o    (aw_bar_o),
        .ax_dom_o    (aw_domain_o),
        .ax_prot_o   (aw_prot_o),
        .ax_is_bar_o (aw_is_bar)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    chk_pair_attrs_match: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ar_is_bar && aw_is_bar) |-> (ar_bar_o == aw_bar_o) && (ar_domain_o == aw_domain_o)
                                     && (ar_prot_o == aw_prot_o))
        else $error("barrier halves differ in attributes");

    chk_bar_id_ext: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ar_valid_o && ar_is_bar) |-> (ar_id_o == AR_BAR_ID) && (AWID_W'(ar_id_o) == AW_BAR_ID))
        else $error("barrier id not zero extended");

    chk_pair_order: assert property (@(posedge mclk_i) disable iff (srst_i)
        accept |=> ar_half_r && aw_half_r && !bar_req_ready_o)
        else $error("new pair accepted before previous halves left");

    chk_cnt_limit: assert property (@(posedge mclk_i) disable iff (srst_i)
        !LITE |-> (cnt_r <= BPI_CNT_LIMIT) && ((cnt_r != BPI_CNT_LIMIT) || !bar_req_ready_o))
        else $error("outstanding barrier limit exceeded");

    chk_cnt_track: assert property (@(posedge mclk_i) disable iff (srst_i)
        (accept && !done) |=> (cnt_r == $past(cnt_r) + 9'h001))
        else $error("outstanding count did not rise on new pair");

    chk_ordered_fence: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rd_req_valid_i && rd_req_ordered_i && rd_req_ready_o) || (wr_req_valid_i && wr_req_ordered_i
        && wr_req_ready_o) |-> fence_clr)
        else $error("ordered request let through an open barrier");

    chk_cache_fence: assert property (@(posedge mclk_i) disable iff (srst_i)
        (cache_st_go_o || cache_ld_go_o) |-> (cnt_r == BPI_CNT_RST))
        else $error("cache access let through an open barrier");

    chk_wr_half_prompt: assert property (@(posedge mclk_i) disable iff (srst_i)
        (aw_half_r && !aw_valid_o && !snp_wr_valid_i) |=> !aw_half_r && aw_valid_o && aw_is_bar)
        else $error("write half held back with slot free");

    chk_rd_half_prompt: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ar_half_r && !ar_valid_o) |=> !ar_half_r && ar_valid_o && ar_is_bar)
        else $error("read half held back with slot free");

    chk_snoop_flow: assert property (@(posedge mclk_i) disable iff (srst_i)
        (snp_wr_valid_i && !aw_valid_o) |-> snp_wr_ready_o ##1 (aw_valid_o && !aw_is_bar))
        else $error("snoop write blocked");

    chk_bar_id_reuse: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rd_req_valid_i && rd_req_ready_o && (rd_req_id_i == AR_BAR_ID)) |-> fence_clr)
        else $error("barrier id reused while barrier open");

endmodule

`default_nettype wire

// File: bpi_pkg.sv
package bpi_pkg;

    // ************************************************************
    // Barrier bookkeeping
    // ************************************************************
    localparam int          BPI_MAX_OUT   = 256;
    localparam int          BPI_CNT_W     = 9;
    localparam logic [8:0]  BPI_CNT_RST   = 9'h000;
    localparam logic [8:0]  BPI_CNT_LIMIT = 9'h100;

    // ************************************************************
    // Address channel field layout and reset values
    // ************************************************************
    localparam int          BPI_BAR_W     = 2;
    localparam int          BPI_DOM_W     = 2;
    localparam int          BPI_PROT_W    = 3;
    localparam logic [1:0]  BPI_BAR_NONE  = 2'h0;
    localparam logic [1:0]  BPI_DOM_RST   = 2'h0;
    localparam logic [2:0]  BPI_PROT_RST  = 3'h0;

    // ************************************************************
    // Address slot occupant
    // ************************************************************
    typedef enum logic [1:0] {
        BPI_SLOT_IDLE = 2'b00,
        BPI_SLOT_BAR  = 2'b01,
        BPI_SLOT_USR  = 2'b10,
        BPI_SLOT_PRI  = 2'b11
    } bpi_slot_e;

endpackage

// File: bpi_addr_slot.sv
`timescale 1ns/1ps
`default_nettype none

module bpi_addr_slot
    import bpi_pkg::*;
#(
    parameter int ID_W   = 4,
    parameter int ADDR_W = 32
) (
    input  wire logic                  mclk_i,
    input  wire logic                  srst_i,
    input  wire logic                  pri_valid_i,
    output logic                       pri_ready_o,
    input  wire logic [ID_W-1:0]       pri_id_i,
    input  wire logic [ADDR_W-1:0]     pri_addr_i,
    input  wire logic                  bar_want_i,
    input  wire logic [ID_W-1:0]       bar_id_i,
    input  wire logic [BPI_BAR_W-1:0]  bar_kind_i,
    input  wire logic [BPI_DOM_W-1:0]  bar_dom_i,
    input  wire logic [BPI_PROT_W-1:0] bar_prot_i,
    output logic                       bar_load_o,
    input  wire logic                  usr_valid_i,
    output logic                       usr_ready_o,
    input  wire logic [ID_W-1:0]       usr_id_i,
    input  wire logic [ADDR_W-1:0]     usr_addr_i,
    input  wire logic [BPI_DOM_W-1:0]  usr_dom_i,
    input  wire logic [BPI_PROT_W-1:0] usr_prot_i,
    output logic                       ax_valid_o,
    input  wire logic                  ax_ready_i,
    output logic [ID_W-1:0]            ax_id_o,
    output logic [ADDR_W-1:0]          ax_addr_o,
    output logic [BPI_BAR_W-1:0]       ax_bar_o,
    output logic [BPI_DOM_W-1:0]       ax_dom_o,
    output logic [BPI_PROT_W-1:0]      ax_prot_o,
    output logic                       ax_is_bar_o
);

    // ************************************************************
    // Slot: holds one request stable until the handshake
    // ************************************************************
    bpi_slot_e              occ_r,  occ_nxt;
    logic [ID_W-1:0]        id_r,   id_nxt;
    logic [ADDR_W-1:0]      addr_r, addr_nxt;
    logic [BPI_BAR_W-1:0]   bar_r,  bar_nxt;
    logic [BPI_DOM_W-1:0]   dom_r,  dom_nxt;
    logic [BPI_PROT_W-1:0]  prot_r, prot_nxt;
    logic                   empty;

    assign empty       = (occ_r == BPI_SLOT_IDLE);
    // Snoop completion traffic first so a barrier never starves it
    assign pri_ready_o = empty && pri_valid_i;
    assign bar_load_o  = empty && !pri_valid_i && bar_want_i;
    assign usr_ready_o = empty && !pri_valid_i && !bar_want_i;

    always_comb begin
        occ_nxt  = occ_r;
        id_nxt   = id_r;
        addr_nxt = addr_r;
        bar_nxt  = bar_r;
        dom_nxt  = dom_r;
        prot_nxt = prot_r;
        if (!empty && ax_ready_i) begin
            occ_nxt = BPI_SLOT_IDLE;
        end
        if (pri_ready_o) begin
            occ_nxt  = BPI_SLOT_PRI;
            id_nxt   = pri_id_i;
            addr_nxt = pri_addr_i;
            bar_nxt  = BPI_BAR_NONE;
            dom_nxt  = BPI_DOM_RST;
            prot_nxt = BPI_PROT_RST;
        end else if (bar_load_o) begin
            occ_nxt  = BPI_SLOT_BAR;
            id_nxt   = bar_id_i;
            addr_nxt = '0;
            bar_nxt  = bar_kind_i;
            dom_nxt  = bar_dom_i;
            prot_nxt = bar_prot_i;
        end else if (usr_ready_o && usr_valid_i) begin
            occ_nxt  = BPI_SLOT_USR;
            id_nxt   = usr_id_i;
            addr_nxt = usr_addr_i;
            bar_nxt  = BPI_BAR_NONE;
            dom_nxt  = usr_dom_i;
            prot_nxt = usr_prot_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            occ_r  <= BPI_SLOT_IDLE;
            id_r   <= '0;
            addr_r <= '0;
            bar_r  <= BPI_BAR_NONE;
            dom_r  <= BPI_DOM_RST;
            prot_r <= BPI_PROT_RST;
        end else begin
            occ_r  <= occ_nxt;
            id_r   <= id_nxt;
            addr_r <= addr_nxt;
            bar_r  <= bar_nxt;
            dom_r  <= dom_nxt;
            prot_r <= prot_nxt;
        end
    end

    assign ax_valid_o  = !empty;
    assign ax_id_o     = id_r;
    assign ax_addr_o   = addr_r;
    assign ax_bar_o    = bar_r;
    assign ax_dom_o    = dom_r;
    assign ax_prot_o   = prot_r;
    assign ax_is_bar_o = (occ_r == BPI_SLOT_BAR);

endmodule

`default_nettype wire

// File: bpi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Downstream slave: accepts address beats, answers in order
// ************************************************************
module bpi_slave_model (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       ar_stall_i,
    input  wire logic       resp_en_i,
    input  wire logic       ar_valid_i,
    input  wire logic [3:0] ar_id_i,
    output logic            ar_ready_o,
    input  wire logic       aw_valid_i,
    input  wire logic [5:0] aw_id_i,
    output logic            aw_ready_o,
    output logic            r_valid_o,
    input  wire logic       r_ready_i,
    output logic [3:0]      r_id_o,
    output logic            r_last_o,
    output logic            b_valid_o,
    input  wire logic       b_ready_i,
    output logic [5:0]      b_id_o
);
    logic [3:0] rq[$];
    logic [5:0] bq[$];

    assign ar_ready_o = !ar_stall_i;
    assign aw_ready_o = 1'b1;

    // Released lines show the inverse of their last value
    always @(posedge mclk_i) begin
        if (srst_i) begin
            rq.delete();
            bq.delete();
            r_valid_o <= 1'b0;
            b_valid_o <= 1'b0;
            r_last_o  <= 1'b0;
            r_id_o    <= 4'h0;
            b_id_o    <= 6'h00;
        end else begin
            if (ar_valid_i && ar_ready_o) rq.push_back(ar_id_i);
            if (aw_valid_i && aw_ready_o) bq.push_back(aw_id_i);
            if (r_valid_o && r_ready_i) begin
                r_valid_o <= 1'b0;
                r_last_o  <= 1'b0;
                r_id_o    <= ~r_id_o;
            end else if (!r_valid_o && resp_en_i && rq.size() > 0) begin
                r_valid_o <= 1'b1;
                r_last_o  <= 1'b1;
                r_id_o    <= rq.pop_front();
            end
            if (b_valid_o && b_ready_i) begin
                b_valid_o <= 1'b0;
                b_id_o    <= ~b_id_o;
            end else if (!b_valid_o && resp_en_i && bq.size() > 0) begin
                b_valid_o <= 1'b1;
                b_id_o    <= bq.pop_front();
            end
        end
    end
endmodule

`default_nettype wire

// File: bpi_barrier_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module bpi_barrier_ctrl_tb_top;
    logic mclk_i = 0, srst_i = 1, ar_stall = 0, resp_en = 0;
    logic bar_req_valid_i = 0, rd_req_valid_i = 0, rd_req_ordered_i = 0, wr_req_valid_i = 0, wr_req_ordered_i = 0;
    logic snp_wr_valid_i = 0, cache_ld_req_i = 0, cache_st_req_i = 0, usr_r_ready_i = 1, usr_b_ready_i = 1;
    logic [1:0] bar_req_kind_i = 0, bar_req_dom_i = 0, rd_req_dom_i = 0, wr_req_dom_i = 0;
    logic [2:0] bar_req_prot_i = 0, rd_req_prot_i = 0, wr_req_prot_i = 0;
    logic [3:0] rd_req_id_i = 0, ar_id_o, r_id_i;
    logic [5:0] wr_req_id_i = 0, snp_wr_id_i = 0, aw_id_o, b_id_i;
    logic [31:0] rd_req_addr_i = 0, wr_req_addr_i = 0, snp_wr_addr_i = 0, ar_addr_o, aw_addr_o;
    logic bar_req_ready_o, rd_req_ready_o, wr_req_ready_o, snp_wr_ready_o, cache_ld_go_o, cache_st_go_o;
    logic ar_valid_o, aw_valid_o, r_ready_o, usr_r_valid_o, b_ready_o, usr_b_valid_o;
    logic ar_ready_i, aw_ready_i, r_valid_i, r_last_i, b_valid_i;
    logic [1:0] ar_bar_o, aw_bar_o, ar_domain_o, aw_domain_o;
    logic [2:0] ar_prot_o, aw_prot_o;
    logic [8:0] bar_outstanding_o;
    int errors = 0, cmp_count = 0, cyc = 0;

    bpi_barrier_ctrl i_dut (.mclk_i, .srst_i, .bar_req_valid_i, .bar_req_ready_o, .bar_req_kind_i,
        .bar_req_dom_i, .bar_req_prot_i, .rd_req_valid_i, .rd_req_ready_o, .rd_req_ordered_i, .rd_req_id_i,
        .rd_req_addr_i, .rd_req_dom_i, .rd_req_prot_i, .wr_req_valid_i, .wr_req_ready_o, .wr_req_ordered_i,
        .wr_req_id_i, .wr_req_addr_i, .wr_req_dom_i, .wr_req_prot_i, .snp_wr_valid_i, .snp_wr_ready_o,
        .snp_wr_id_i, .snp_wr_addr_i, .cache_ld_req_i, .cache_ld_go_o, .cache_st_req_i, .cache_st_go_o,
        .ar_valid_o, .ar_ready_i, .ar_id_o, .ar_addr_o, .ar_bar_o, .ar_domain_o, .ar_prot_o, .aw_valid_o,
        .aw_ready_i, .aw_id_o, .aw_addr_o, .aw_bar_o, .aw_domain_o, .aw_prot_o, .r_valid_i, .r_ready_o,
        .r_id_i, .r_last_i, .usr_r_valid_o, .usr_r_ready_i, .b_valid_i, .b_ready_o, .b_id_i,
        .usr_b_valid_o, .usr_b_ready_i, .bar_outstanding_o);

    bpi_slave_model i_slv (.mclk_i, .srst_i, .ar_stall_i(ar_stall), .resp_en_i(resp_en),
        .ar_valid_i(ar_valid_o), .ar_id_i(ar_id_o), .ar_ready_o(ar_ready_i), .aw_valid_i(aw_valid_o),
        .aw_id_i(aw_id_o), .aw_ready_o(aw_ready_i), .r_valid_o(r_valid_i), .r_ready_i(r_ready_o),
        .r_id_o(r_id_i), .r_last_o(r_last_i), .b_valid_o(b_valid_i), .b_ready_i(b_ready_o), .b_id_o(b_id_i));

    always #50 mclk_i = ~mclk_i;

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ************************************************************
    // Handshake helpers, entered at a falling edge
    // ************************************************************
    task automatic bar_issue(input logic [1:0] k, input logic [1:0] d, input logic [2:0] p);
        int n;
        n = 0;
        bar_req_kind_i = k;
        bar_req_dom_i = d;
        bar_req_prot_i = p;
        bar_req_valid_i = 1'b1;
        while (!bar_req_ready_o && n < 50) begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
        bar_req_valid_i = 1'b0;
    endtask

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (bar_outstanding_o !== 9'h000 && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("outstanding", 9'h000, bar_outstanding_o)
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic s_pair();
        resp_en = 1'b0;
        cache_ld_req_i = 1'b1;
        cache_st_req_i = 1'b1;
        bar_issue(2'h1, 2'h2, 3'h5);
        @(negedge mclk_i);
        `CHK("ar_id", 4'hf, ar_id_o)
        `CHK("aw_id", 6'h0f, aw_id_o)
        `CHK("ar_bar", 2'h1, ar_bar_o)
        `CHK("aw_bar", 2'h1, aw_bar_o)
        `CHK("ar_dom", 2'h2, ar_domain_o)
        `CHK("aw_dom", 2'h2, aw_domain_o)
        `CHK("ar_prot", 3'h5, ar_prot_o)
        `CHK("aw_prot", 3'h5, aw_prot_o)
        `CHK("count", 9'h001, bar_outstanding_o)
        `CHK("ld_go", 1'b0, cache_ld_go_o)
        `CHK("st_go", 1'b0, cache_st_go_o)
        repeat (4) @(negedge mclk_i);
        `CHK("count", 9'h001, bar_outstanding_o)
        rd_req_ordered_i = 1'b1;
        wr_req_ordered_i = 1'b1;
        #1;
        `CHK("rd_ord_ready", 1'b0, rd_req_ready_o)
        `CHK("wr_ord_ready", 1'b0, wr_req_ready_o)
        rd_req_ordered_i = 1'b0;
        wr_req_ordered_i = 1'b0;
        rd_req_id_i = 4'h1;
        wr_req_id_i = 6'h02;
        rd_req_addr_i = 32'h00000040;
        wr_req_addr_i = 32'h00000080;
        rd_req_valid_i = 1'b1;
        wr_req_valid_i = 1'b1;
        #1;
        `CHK("rd_ready", 1'b1, rd_req_ready_o)
        `CHK("wr_ready", 1'b1, wr_req_ready_o)
        @(negedge mclk_i);
        rd_req_valid_i = 1'b0;
        wr_req_valid_i = 1'b0;
        `CHK("ar_valid", 1'b1, ar_valid_o)
        `CHK("ar_id", 4'h1, ar_id_o)
        `CHK("aw_id", 6'h02, aw_id_o)
        `CHK("ar_addr", 32'h00000040, ar_addr_o)
        `CHK("aw_addr", 32'h00000080, aw_addr_o)
        resp_en = 1'b1;
        wait_idle(50);
        `CHK("ld_go", 1'b1, cache_ld_go_o)
        `CHK("st_go", 1'b1, cache_st_go_o)
        cache_ld_req_i = 1'b0;
        cache_st_req_i = 1'b0;
    endtask

    task automatic s_snoop();
        int n;
        n = 0;
        ar_stall = 1'b1;
        resp_en = 1'b0;
        bar_issue(2'h0, 2'h0, 3'h0);
        snp_wr_id_i = 6'h03;
        snp_wr_valid_i = 1'b1;
        while (!snp_wr_ready_o && n < 20) begin
            @(negedge mclk_i);
            n++;
        end
        @(negedge mclk_i);
        snp_wr_valid_i = 1'b0;
        `CHK("snp_aw_valid", 1'b1, aw_valid_o)
        `CHK("snp_aw_id", 6'h03, aw_id_o)
        `CHK("ar_held", 1'b1, ar_valid_o)
        ar_stall = 1'b0;
        resp_en = 1'b1;
        wait_idle(50);
    endtask

    task automatic s_limit();
        resp_en = 1'b0;
        for (int i = 0; i < 256; i++) begin
            bar_issue(2'h0, 2'h3, 3'h0);
            @(negedge mclk_i);
        end
        repeat (4) @(negedge mclk_i);
        `CHK("count_max", 9'h100, bar_outstanding_o)
        `CHK("bar_ready", 1'b0, bar_req_ready_o)
        resp_en = 1'b1;
        wait_idle(2000);
    endtask

    initial begin
        repeat (16) @(negedge mclk_i);
        srst_i = 1'b0;
        s_pair();
        s_snoop();
        s_limit();
        end_of_test();
    end
endmodule

`default_nettype wire
